// *** rtl/sam_pkg.sv ***
`default_nettype none

package sam_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] SAM_OFS_CFG    = 12'h000;
  localparam logic [11:0] SAM_OFS_STATUS = 12'h004;
  localparam logic [11:0] SAM_OFS_RESULT = 12'h008;

  // ----------------------------------------------------------------------
  // Fields of memory_geometry_config
  // ----------------------------------------------------------------------
  localparam int          SAM_CFG_COL_LSB  = 0;
  localparam int          SAM_CFG_ROW_LSB  = 2;
  localparam int          SAM_CFG_BUS32    = 4;
  localparam int          SAM_CFG_ILEAVE   = 5;
  localparam int          SAM_CFG_USED_W   = 6;
  localparam logic [5:0]  SAM_CFG_RESET    = 6'h00;

  // ----------------------------------------------------------------------
  // Fields of the status and result registers
  // ----------------------------------------------------------------------
  localparam int          SAM_ST_ILLEGAL   = 0;
  localparam int          SAM_ST_VALID     = 1;
  localparam int          SAM_RES_ROW_LSB  = 12;
  localparam int          SAM_RES_BANK_LSB = 26;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int          SAM_COL_MAX_W    = 12;
  localparam int          SAM_ROW_MAX_W    = 14;
  localparam int          SAM_BANK_W       = 2;
  localparam logic [5:0]  SAM_COL_BASE_W   = 6'h09;
  localparam logic [5:0]  SAM_ROW_BASE_W   = 6'h0B;
  localparam logic [5:0]  SAM_OFS16_W      = 6'h01;
  localparam logic [5:0]  SAM_OFS32_W      = 6'h02;
  localparam logic [1:0]  SAM_COL_CODE_4K  = 2'h3;
  localparam logic [1:0]  SAM_ROW_CODE_16K = 2'h3;

  typedef enum logic [0:0] {
    SAM_MAP_LINEAR = 1'b0,
    SAM_MAP_ILEAVE = 1'b1
  } sam_mode_t;

endpackage

`default_nettype wire

// *** rtl/sam_map_if.sv ***
`default_nettype none

interface sam_map_if;
  import sam_pkg::*;
  logic [31:0]                addr;
  logic [1:0]                 col_code;
  logic [1:0]                 row_code;
  logic                       bus32;
  sam_mode_t                  mode;
  logic [SAM_BANK_W-1:0]      bank;
  logic [SAM_ROW_MAX_W-1:0]   row;
  logic [SAM_COL_MAX_W-1:0]   col;
  logic [1:0]                 byte_ofs;
  logic                       illegal;

  modport splitter (input addr, col_code, row_code, bus32, mode,
                    output bank, row, col, byte_ofs, illegal);
  modport user     (output addr, col_code, row_code, bus32, mode,
                    input bank, row, col, byte_ofs, illegal);
endinterface

`default_nettype wire

// *** rtl/sam_split.sv ***
`default_nettype none

module sam_split
  import sam_pkg::*;
(
  sam_map_if.splitter m
);

  logic [5:0]  ofs_w;
  logic [5:0]  col_w;
  logic [5:0]  row_w;
  logic [5:0]  col_sh;
  logic [5:0]  row_sh;
  logic [5:0]  bank_sh;
  logic [31:0] col_mask;
  logic [31:0] row_mask;
  logic [31:0] col_raw;
  logic [31:0] row_raw;
  logic [31:0] bank_raw;
  logic [1:0]  col_code_eff;

  // ----------------------------------------------------------------------
  // Field widths and positions
  // ----------------------------------------------------------------------
  always_comb begin
    // A 16K-row part has no 4096-column option; such a setting is flagged
    // and mapped as 2048 columns so the fields never overlap.
    m.illegal    = (m.row_code == SAM_ROW_CODE_16K) && (m.col_code == SAM_COL_CODE_4K);
    col_code_eff = m.illegal ? 2'h2 : m.col_code;
    ofs_w        = m.bus32 ? SAM_OFS32_W : SAM_OFS16_W;
    col_w        = SAM_COL_BASE_W + {4'h0, col_code_eff};
    row_w        = SAM_ROW_BASE_W + {4'h0, m.row_code};
    col_sh       = ofs_w;
    if (m.mode == SAM_MAP_LINEAR) begin
      row_sh  = ofs_w + col_w;
      bank_sh = ofs_w + col_w + row_w;
    end else begin
      bank_sh = ofs_w + col_w;
      row_sh  = ofs_w + col_w + 6'(SAM_BANK_W);
    end
  end

  // ----------------------------------------------------------------------
  // Extraction; masks drop every address bit above the used fields
  // ----------------------------------------------------------------------
  always_comb begin
    col_mask   = ~(32'hFFFFFFFF << col_w);
    row_mask   = ~(32'hFFFFFFFF << row_w);
    col_raw    = (m.addr >> col_sh) & col_mask;
    row_raw    = (m.addr >> row_sh) & row_mask;
    bank_raw   = (m.addr >> bank_sh) & 32'h00000003;
    m.col      = col_raw[SAM_COL_MAX_W-1:0];
    m.row      = row_raw[SAM_ROW_MAX_W-1:0];
    m.bank     = bank_raw[SAM_BANK_W-1:0];
    m.byte_ofs = m.bus32 ? m.addr[1:0] : {1'b0, m.addr[0]};
  end

endmodule

`default_nettype wire

// *** rtl/sam_top.sv ***
// Implementation choices: the APB slave port and the placing of the registers.
`default_nettype none

module sam_top
  import sam_pkg::*;
#(
  parameter int APB_ADDR_W = 12
)(
  input  wire logic                     MCLK,
  input  wire logic                     RESET,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [APB_ADDR_W-1:0]    PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  input  wire logic                     REQ_VALID,
  input  wire logic [31:0]              REQ_ADDR,
  output logic                          MAP_VALID,
  output logic      [SAM_BANK_W-1:0]    MAP_BANK,
  output logic      [SAM_ROW_MAX_W-1:0] MAP_ROW,
  output logic      [SAM_COL_MAX_W-1:0] MAP_COL,
  output logic      [1:0]               MAP_BYTE_OFS
);

  sam_map_if m ();

  logic [SAM_CFG_USED_W-1:0] memory_geometry_config_r;
  logic [SAM_CFG_USED_W-1:0] memory_geometry_config_nxt;
  logic [31:0]               prdata_r;
  logic [31:0]               prdata_nxt;
  logic                      map_valid_r;
  logic                      map_valid_nxt;
  logic                      seen_r;
  logic                      seen_nxt;
  logic [SAM_BANK_W-1:0]     bank_r;
  logic [SAM_BANK_W-1:0]     bank_nxt;
  logic [SAM_ROW_MAX_W-1:0]  row_r;
  logic [SAM_ROW_MAX_W-1:0]  row_nxt;
  logic [SAM_COL_MAX_W-1:0]  col_r;
  logic [SAM_COL_MAX_W-1:0]  col_nxt;
  logic [1:0]                ofs_r;
  logic [1:0]                ofs_nxt;
  logic [11:0]               reg_ofs;
  logic                      mapped;
  logic                      setup;
  logic                      wr_cfg;
  logic [31:0]               result_word;

  // ----------------------------------------------------------------------
  // Address splitter
  // ----------------------------------------------------------------------
  assign m.addr     = REQ_ADDR;
  assign m.col_code = memory_geometry_config_r[SAM_CFG_COL_LSB +: 2];
  assign m.row_code = memory_geometry_config_r[SAM_CFG_ROW_LSB +: 2];
  assign m.bus32    = memory_geometry_config_r[SAM_CFG_BUS32];
  assign m.mode     = sam_mode_t'(memory_geometry_config_r[SAM_CFG_ILEAVE]);

  sam_split u_split (
    .m (m.splitter)
  );

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle.
  // Read data is captured in the setup cycle so PRDATA comes from a flop.
  always_comb begin
    reg_ofs = 12'(PADDR);
    mapped  = (reg_ofs == SAM_OFS_CFG) || (reg_ofs == SAM_OFS_STATUS) || (reg_ofs == SAM_OFS_RESULT);
    setup   = PSEL && !PENABLE;
    wr_cfg  = PSEL && PENABLE && PWRITE && (reg_ofs == SAM_OFS_CFG);
    PREADY  = PSEL && PENABLE;
    PSLVERR = PSEL && PENABLE && !mapped;
  end

  always_comb begin
    result_word                                     = 32'h00000000;
    result_word[SAM_COL_MAX_W-1:0]                  = col_r;
    result_word[SAM_RES_ROW_LSB +: SAM_ROW_MAX_W]   = row_r;
    result_word[SAM_RES_BANK_LSB +: SAM_BANK_W]     = bank_r;
  end

  always_comb begin
    memory_geometry_config_nxt = memory_geometry_config_r;
    if (wr_cfg) begin
      memory_geometry_config_nxt = PWDATA[SAM_CFG_USED_W-1:0];
    end
    prdata_nxt = prdata_r;
    if (setup && !PWRITE) begin
      prdata_nxt = 32'h00000000;
      if (reg_ofs == SAM_OFS_CFG) begin
        prdata_nxt[SAM_CFG_USED_W-1:0] = memory_geometry_config_r;
      end else if (reg_ofs == SAM_OFS_STATUS) begin
        prdata_nxt[SAM_ST_ILLEGAL] = m.illegal;
        prdata_nxt[SAM_ST_VALID]   = seen_r;
      end else if (reg_ofs == SAM_OFS_RESULT) begin
        prdata_nxt = result_word;
      end
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      memory_geometry_config_r <= SAM_CFG_RESET;
      prdata_r                 <= 32'h00000000;
    end else begin
      memory_geometry_config_r <= memory_geometry_config_nxt;
      prdata_r                 <= prdata_nxt;
    end
  end

  assign PRDATA = prdata_r;

  // ----------------------------------------------------------------------
  // Mapping pipeline
  // ----------------------------------------------------------------------
  // One register stage: a request taken at edge N shows its fields after
  // that edge. Changing the geometry while requests flow is allowed, but a
  // request in the same cycle as the write still uses the old geometry.
  always_comb begin
    map_valid_nxt = REQ_VALID;
    seen_nxt      = seen_r || REQ_VALID;
    bank_nxt      = bank_r;
    row_nxt       = row_r;
    col_nxt       = col_r;
    ofs_nxt       = ofs_r;
    if (REQ_VALID) begin
      bank_nxt = m.bank;
      row_nxt  = m.row;
      col_nxt  = m.col;
      ofs_nxt  = m.byte_ofs;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      map_valid_r <= 1'b0;
      seen_r      <= 1'b0;
      bank_r      <= '0;
      row_r       <= '0;
      col_r       <= '0;
      ofs_r       <= 2'h0;
    end else begin
      map_valid_r <= map_valid_nxt;
      seen_r      <= seen_nxt;
      bank_r      <= bank_nxt;
      row_r       <= row_nxt;
      col_r       <= col_nxt;
      ofs_r       <= ofs_nxt;
    end
  end

  assign MAP_VALID    = map_valid_r;
  assign MAP_BANK     = bank_r;
  assign MAP_ROW      = row_r;
  assign MAP_COL      = col_r;
  assign MAP_BYTE_OFS = ofs_r;

endmodule

`default_nettype wire

// *** sim/sam_ref.svh ***
`ifndef SAM_REF_SVH
`define SAM_REF_SVH
// Reference split, packed as {bank, row, col, byte offset}.
function automatic logic [29:0] sam_ref_map(input logic [5:0] c, input logic [31:0] a);
  int          cw;
  int          rw;
  logic [31:0] s;
  logic [29:0] r;
  cw = 9 + int'(c[1:0]);
  rw = 11 + int'(c[3:2]);
  if (c[3:0] == 4'hF) cw = 11;
  s = c[4] ? (a >> 2) : (a >> 1);
  r[1:0] = c[4] ? a[1:0] : {1'b0, a[0]};
  r[13:2] = 12'(s & ((32'h1 << cw) - 32'h1));
  s = s >> cw;
  r[29:28] = s[1:0];
  if (c[5]) s = s >> 2;
  r[27:14] = 14'(s & ((32'h1 << rw) - 32'h1));
  if (!c[5]) r[29:28] = 2'(s >> rw);
  return r;
endfunction
`endif

// *** sim/sam_req_model.sv ***
`default_nettype none
module sam_req_model (
  input  wire logic        clk,
  output logic             req_valid,
  output logic [31:0]      req_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_valid = 1'b0;
    req_addr  = 32'h0;
  end
  // A released address bus shows the inverse, so stale values never look valid.
  task automatic send(input logic [31:0] a);
    @(posedge clk);
    req_valid <= 1'b1;
    req_addr  <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    req_addr  <= ~a;
  endtask
endmodule
`default_nettype wire

// *** sim/sam_top_properties.sv ***
`default_nettype none
`include "sam_ref.svh"
module sam_top_properties
  import sam_pkg::*;
#(
  parameter int APB_ADDR_W = 12
)(
  input wire logic                     MCLK,
  input wire logic                     RESET,
  input wire logic                     PSEL,
  input wire logic                     PENABLE,
  input wire logic                     PWRITE,
  input wire logic [APB_ADDR_W-1:0]    PADDR,
  input wire logic [31:0]              PWDATA,
  input wire logic [31:0]              PRDATA,
  input wire logic                     PREADY,
  input wire logic                     PSLVERR,
  input wire logic                     REQ_VALID,
  input wire logic [31:0]              REQ_ADDR,
  input wire logic                     MAP_VALID,
  input wire logic [SAM_BANK_W-1:0]    MAP_BANK,
  input wire logic [SAM_ROW_MAX_W-1:0] MAP_ROW,
  input wire logic [SAM_COL_MAX_W-1:0] MAP_COL,
  input wire logic [1:0]               MAP_BYTE_OFS
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0]  cfg_r;
  logic [5:0]  cfg_nxt;
  logic [29:0] exp_map;
  always_comb begin
    cfg_nxt = cfg_r;
    if (PSEL && PENABLE && PWRITE && PADDR == APB_ADDR_W'(SAM_OFS_CFG)) cfg_nxt = PWDATA[5:0];
  end
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) cfg_r <= SAM_CFG_RESET;
    else cfg_r <= cfg_nxt;
  end
  assign exp_map = sam_ref_map(cfg_r, REQ_ADDR);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  sequence s_req;
    REQ_VALID;
  endsequence
  a_map_pulse: assert property (s_req |=> MAP_VALID) else $error("map valid missing");
  a_no_spurious: assert property (!REQ_VALID |=> !MAP_VALID) else $error("map valid spurious");
  a_col_field: assert property (s_req |=> MAP_COL == $past(exp_map[13:2])) else $error("column wrong");
  a_ofs_field: assert property (s_req |=> MAP_BYTE_OFS == $past(exp_map[1:0])) else $error("offset wrong");
  a_row_linear: assert property (s_req ##0 !cfg_r[5] |=> MAP_ROW == $past(exp_map[27:14]))
    else $error("linear row wrong");
  a_row_ileave: assert property (s_req ##0 cfg_r[5] |=> MAP_ROW == $past(exp_map[27:14]))
    else $error("interleaved row wrong");
  a_bank_field: assert property (s_req |=> MAP_BANK == $past(exp_map[29:28])) else $error("bank wrong");
  a_fields_hold: assert property (
    !REQ_VALID |=> $stable(MAP_COL) && $stable(MAP_ROW) && $stable(MAP_BANK)) else $error("fields moved");
  a_apb_ready: assert property (PSEL && PENABLE |-> PREADY) else $error("ready missing");
endmodule
bind sam_top sam_top_properties #(.APB_ADDR_W(APB_ADDR_W)) sam_top_properties_inst (.MCLK(MCLK), .RESET(RESET),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR), .MAP_VALID(MAP_VALID),
  .MAP_BANK(MAP_BANK), .MAP_ROW(MAP_ROW), .MAP_COL(MAP_COL), .MAP_BYTE_OFS(MAP_BYTE_OFS));
`default_nettype wire

// *** sim/test_sdram_address_mapper.sv ***
`default_nettype none
`include "sam_ref.svh"
module test_sdram_address_mapper
  import sam_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        req_valid;
  logic [31:0] req_addr;
  logic        map_valid;
  logic [1:0]  map_bank;
  logic [13:0] map_row;
  logic [11:0] map_col;
  logic [1:0]  map_ofs;
  logic [31:0] rd;
  logic        er;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #2 mclk = ~mclk;
  sam_req_model sam_req_model_inst (.clk(mclk), .req_valid(req_valid), .req_addr(req_addr));
  sam_top sam_top_inst (.MCLK(mclk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .REQ_VALID(req_valid),
    .REQ_ADDR(req_addr), .MAP_VALID(map_valid), .MAP_BANK(map_bank), .MAP_ROW(map_row), .MAP_COL(map_col),
    .MAP_BYTE_OFS(map_ofs));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees ready.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic map_chk(input logic [5:0] c, input logic [31:0] a);
    logic [29:0] x;
    x = sam_ref_map(c, a);
    sam_req_model_inst.send(a);
    #1;
    chk("map_valid", 32'h1, {31'h0, map_valid});
    chk("map_col", {20'h0, x[13:2]}, {20'h0, map_col});
    chk("map_row", {18'h0, x[27:14]}, {18'h0, map_row});
    chk("map_bank", {30'h0, x[29:28]}, {30'h0, map_bank});
    chk("map_byte_ofs", {30'h0, x[1:0]}, {30'h0, map_ofs});
    apb(1'b0, SAM_OFS_RESULT, 32'h0);
    chk("result", {4'h0, x[29:2]}, rd);
  endtask
  task automatic t_reset_unmapped();
    apb(1'b0, SAM_OFS_CFG, 32'h0);
    chk("cfg_reset", 32'h0, rd);
    chk("cfg_err", 32'h0, {31'h0, er});
    apb(1'b0, SAM_OFS_STATUS, 32'h0);
    chk("status_reset", 32'h0, rd);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
  endtask
  // Hand-worked page crossing; the high nibble must not disturb the result.
  task automatic t_page_cross();
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, SAM_OFS_CFG, i[0] ? 32'h20 : 32'h0);
      sam_req_model_inst.send(32'hF0000400);
      #1;
      chk("cross_col", 32'h0, {20'h0, map_col});
      chk("cross_row", i[0] ? 32'h0 : 32'h1, {18'h0, map_row});
      chk("cross_bank", i[0] ? 32'h1 : 32'h0, {30'h0, map_bank});
    end
  endtask
  task automatic t_geometries();
    logic [5:0] c;
    for (int i = 0; i < 64; i++) begin
      c = 6'(i);
      apb(1'b1, SAM_OFS_CFG, {26'h0, c});
      apb(1'b0, SAM_OFS_CFG, 32'h0);
      chk("cfg_readback", {26'h0, c}, rd);
      apb(1'b0, SAM_OFS_STATUS, 32'h0);
      chk("status", {30'h0, 1'b1, c[3:0] == 4'hF}, rd);
      map_chk(c, 32'hFFFFFFFF);
      map_chk(c, 32'h2C6B5A93 + 32'(i * 32'h01357));
    end
  endtask
  // A reset in mid-run must restore the power-up geometry and clear the mapped fields.
  task automatic t_mid_reset();
    apb(1'b1, SAM_OFS_CFG, 32'h0000003F);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    chk("valid_after_reset", 32'h0, {31'h0, map_valid});
    chk("fields_after_reset", 32'h0, {4'h0, map_bank, map_row, map_col});
    apb(1'b0, SAM_OFS_CFG, 32'h0);
    chk("cfg_after_reset", 32'h0, rd);
    apb(1'b0, SAM_OFS_STATUS, 32'h0);
    chk("status_after_reset", 32'h0, rd);
    map_chk(6'h00, 32'h00ABCDEF);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    t_reset_unmapped();
    t_page_cross();
    t_geometries();
    t_mid_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
